// ===== hw/rbo_byte_order.sv
// receive byte deserializer, byte ordering stage and phase fifo with axi4-lite registers
// Notes on behaviour
// R1: scan every byte slot of each deserialized word for the ordering pattern; double width scans only the even slots 0 and 2.
// R2: pattern found high up: insert pad bytes so it lands in slot zero.
// R3: ordering needs deserializer on, ordering pattern and pad pattern both programmed.
// R4: single width joins two 8/10-bit bytes into one 16/20-bit word.
// R5: double width joins two 16/20-bit halves into one four-byte word.
// R6: custom single width uses 8-bit ordering and pad patterns.
// R7: custom double width supports programmable patterns, 32-bit fabric word; here the fabric word is always 40 bits, four 10-bit slots.
// R8: software must pick a pattern the far transmitter places in low bytes.
// R9: phase fifo holds four words of data and status.
// R10: fifo written by the receive parallel clock, read by the fabric clock; here one clk drives both sides.
// R11: read and write clocks must match exactly, else underrun or overflow.
// R12: registered mode passes data with exactly one cycle of latency.
// R13: once aligned, keep the alignment until reset or re-arm; here clearing the ordering enable or deserializer enable also drops it.
//
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module rbo_byte_order import rbo_pkg::*; (
  input wire logic clk, // 20 MHz word clock
  input wire logic rstn, // async reset, active low
  input wire logic [IN_W-1:0] inData, // one byte (low 10) or two bytes
  input wire logic inValid, // input byte valid
  output logic inReady, // input byte accepted when high with inValid
  output logic [WORD_W-1:0] outData, // four byte slots, slot 0 lowest
  output logic [SLOTS-1:0] outStat, // per slot: byte is an inserted pad
  output logic outValid, // output word valid
  input wire logic outReady, // fabric takes the word
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  output logic [1:0] s_axi_bresp, // write response
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp // read response
);
  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    return (a == REG_CTRL) || (a == REG_ORDPAT) || (a == REG_PADPAT) || (a == REG_STATUS);
  endfunction : isMapped

  function automatic logic [31:0] applyStrb(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction : applyStrb

  function automatic logic byteMatch(input logic [BYTE_W-1:0] b, input logic [BYTE_W-1:0] pat,
                                     input logic narrow);
    return narrow ? (b[7:0] == pat[7:0]) : (b == pat);
  endfunction : byteMatch

  rbo_stream_if #(.W(FIFO_W)) wIf ();
  rbo_stream_if #(.W(FIFO_W)) rIf ();

  logic [CTRL_W-1:0] ctrl;
  logic [BYTE_W-1:0] ordPat;
  logic [BYTE_W-1:0] padPat;
  logic patSet;
  logic padSet;
  logic rearm;
  logic awDone;
  logic wDone;
  logic [ADDR_W-1:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic wrEn;
  logic [31:0] rdMux;
  logic [31:0] statusWord;
  logic deserEn;
  logic dbl;
  logic byte8;
  logic active;
  logic take;
  logic phase;
  logic [IN_W-1:0] half;
  logic [BYTE_W-1:0] wordSlot [SLOTS];
  logic [BYTE_W-1:0] prev [SLOTS];
  logic [BYTE_W-1:0] outSlot [SLOTS];
  logic [SLOTS-1:0] padFlag;
  logic wordValid;
  logic [2:0] nSlots;
  logic [SLOTS-1:0] match;
  logic hit;
  logic [2:0] hitIdx;
  logic detect;
  logic [2:0] off;
  logic [2:0] offEff;
  logic expectPat;
  logic [LVL_W-1:0] level;
  logic [LVL_W:0] next_inReady;
  rbo_ord_t state;
  rbo_ord_t next_state;

  assign deserEn = ctrl[CTRL_DESER_EN];
  assign dbl = ctrl[CTRL_DOUBLE]; // R5 R7
  assign byte8 = ctrl[CTRL_BYTE8]; // R6
  assign active = ctrl[CTRL_ORD_EN] && deserEn && patSet && padSet; // R3
  assign take = inValid && inReady;
  assign wrEn = awDone && wDone && !s_axi_bvalid;

  // axi4-lite write channel: address and data taken in either order
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      awDone <= 1'b0;
      wDone <= 1'b0;
      awAddr <= '0;
      wData <= '0;
      wStrb <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr <= s_axi_awaddr;
        awDone <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
        wDone <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wrEn) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= isMapped(awAddr) ? RESP_OKAY : RESP_SLVERR;
        awDone <= 1'b0;
        wDone <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // writing a pattern register also marks that pattern as programmed
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl <= CTRL_RESET;
      ordPat <= PAT_RESET;
      padPat <= PAT_RESET;
      patSet <= 1'b0;
      padSet <= 1'b0;
      rearm <= 1'b0;
    end else begin
      rearm <= 1'b0;
      if (wrEn && awAddr == REG_CTRL) begin
        ctrl <= CTRL_W'(applyStrb({26'h0, ctrl}, wData, wStrb)) & ~CTRL_W'(1 << CTRL_REARM);
        rearm <= wStrb[0] && wData[CTRL_REARM];
      end
      if (wrEn && awAddr == REG_ORDPAT) begin
        ordPat <= BYTE_W'(applyStrb({22'h0, ordPat}, wData, wStrb));
        patSet <= 1'b1; // R3
      end
      if (wrEn && awAddr == REG_PADPAT) begin
        padPat <= BYTE_W'(applyStrb({22'h0, padPat}, wData, wStrb));
        padSet <= 1'b1; // R3
      end
    end
  end

  always_comb begin
    statusWord = '0;
    statusWord[ST_LOCKED] = state == RBO_LOCKED;
    statusWord[ST_PAT_SET] = patSet;
    statusWord[ST_PAD_SET] = padSet;
    statusWord[ST_SEARCH] = state == RBO_SEARCH;
    statusWord[ST_OFF_LSB +: 3] = off;
    statusWord[ST_LVL_LSB +: LVL_W] = level;
    case (s_axi_araddr)
      REG_CTRL: rdMux = {26'h0, ctrl};
      REG_ORDPAT: rdMux = {22'h0, ordPat};
      REG_PADPAT: rdMux = {22'h0, padPat};
      REG_STATUS: rdMux = statusWord;
      default: rdMux = '0;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdMux;
        s_axi_rresp <= isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // byte deserializer: two input beats make one word
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phase <= 1'b0;
      half <= '0;
      wordValid <= 1'b0;
      for (int i = 0; i < SLOTS; i++) begin
        wordSlot[i] <= '0;
      end
    end else begin
      wordValid <= 1'b0;
      if (!deserEn) begin
        phase <= 1'b0;
      end
      if (take && !deserEn) begin
        wordSlot[0] <= inData[BYTE_W-1:0];
        wordSlot[1] <= dbl ? inData[IN_W-1:BYTE_W] : '0;
        wordSlot[2] <= '0;
        wordSlot[3] <= '0;
        wordValid <= 1'b1;
      end else if (take && !phase) begin
        half <= inData;
        phase <= 1'b1;
      end else if (take) begin
        phase <= 1'b0;
        wordValid <= 1'b1;
        wordSlot[0] <= half[BYTE_W-1:0]; // R4
        wordSlot[1] <= dbl ? half[IN_W-1:BYTE_W] : inData[BYTE_W-1:0]; // R4 R5
        wordSlot[2] <= dbl ? inData[BYTE_W-1:0] : '0; // R5
        wordSlot[3] <= dbl ? inData[IN_W-1:BYTE_W] : '0; // R5
      end
    end
  end

  assign nSlots = deserEn ? (dbl ? 3'h4 : 3'h2) : (dbl ? 3'h2 : 3'h1);

  // double width pattern occupies a byte pair, so only even slots qualify
  for (genvar k = 0; k < SLOTS; k++) begin : g_scan
    assign match[k] = (3'(k) < nSlots) && !(dbl && (k % 2) != 0)
                      && byteMatch(wordSlot[k], ordPat, byte8); // R1 R6 R7
  end

  always_comb begin
    hitIdx = '0;
    for (int k = SLOTS - 1; k >= 0; k--) begin
      if (match[k]) begin
        hitIdx = 3'(k);
      end
    end
  end

  assign hit = |match;
  assign detect = wordValid && state == RBO_SEARCH && hit && active && !rearm;
  assign offEff = (detect && hitIdx != '0) ? (nSlots - hitIdx) : (detect ? '0 : off); // R2

  // low slots take pads on the locking word, then the carried upper bytes of the previous word
  always_comb begin
    for (int j = 0; j < SLOTS; j++) begin
      outSlot[j] = '0;
      padFlag[j] = 1'b0;
      if (3'(j) < nSlots && 3'(j) < offEff) begin
        outSlot[j] = detect ? padPat : prev[2'(nSlots - offEff + 3'(j))]; // R2
        padFlag[j] = detect;
      end else if (3'(j) < nSlots) begin
        outSlot[j] = wordSlot[2'(3'(j) - offEff)];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < SLOTS; i++) begin
        prev[i] <= '0;
      end
    end else if (wordValid) begin
      prev <= wordSlot;
    end
  end

  always_comb begin
    case (state)
      RBO_IDLE: next_state = active ? RBO_SEARCH : RBO_IDLE;
      RBO_SEARCH: next_state = !active ? RBO_IDLE : (detect ? RBO_LOCKED : RBO_SEARCH);
      RBO_LOCKED: next_state = !active ? RBO_IDLE : (rearm ? RBO_SEARCH : RBO_LOCKED); // R13
      default: next_state = RBO_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= RBO_IDLE;
      off <= '0;
    end else begin
      state <= next_state;
      if (next_state != RBO_LOCKED) begin
        off <= '0;
      end else if (detect) begin
        off <= offEff; // R13
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      expectPat <= 1'b0;
    end else if (wordValid) begin
      expectPat <= detect && hitIdx != '0;
    end
  end

  assign wIf.valid = wordValid;
  assign wIf.data = {padFlag, outSlot[3], outSlot[2], outSlot[1], outSlot[0]};

  // room is reserved for the word in flight and one completed by this cycle's take
  assign next_inReady = {1'b0, level} + {3'h0, wordValid} + {3'h0, take} + 4'h1;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      inReady <= 1'b0;
    end else begin
      inReady <= next_inReady <= 4'(PHC_DEPTH); // R11
    end
  end

  // one clock here: rate mismatch cannot arise, back-pressure guards the depth
  rbo_fifo #(.W(FIFO_W), .DEPTH(PHC_DEPTH)) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .bypass(ctrl[CTRL_REG_MODE]),
    .wr(wIf),
    .rd(rIf),
    .level(level)
  ); // R9 R10 R12

  assign rIf.ready = outReady;
  assign outData = rIf.data[WORD_W-1:0];
  assign outStat = rIf.data[FIFO_W-1:WORD_W];
  assign outValid = rIf.valid;

  property p_lockedNeedsCfg;
    @(posedge clk) disable iff (!rstn)
    state == RBO_LOCKED |-> $past(active);
  endproperty
  a_lockedNeedsCfg: assert property (p_lockedNeedsCfg) else $error("locked without config"); // R3

  property p_scanLocks;
    @(posedge clk) disable iff (!rstn)
    (wordValid && state == RBO_SEARCH && |match && active && !rearm) |=> state == RBO_LOCKED;
  endproperty
  a_scanLocks: assert property (p_scanLocks) else $error("pattern seen but not locked"); // R1

  property p_padFirst;
    @(posedge clk) disable iff (!rstn)
    (detect && hitIdx != '0) |-> (outSlot[0] == padPat && padFlag[0]);
  endproperty
  a_padFirst: assert property (p_padFirst) else $error("pad byte missing in slot zero"); // R2

  property p_patLands;
    @(posedge clk) disable iff (!rstn)
    (wordValid && expectPat && state == RBO_LOCKED) |-> byteMatch(outSlot[0], ordPat, byte8);
  endproperty
  a_patLands: assert property (p_patLands) else $error("pattern not moved to slot zero"); // R2

  sequence s_lockedSteady;
    state == RBO_LOCKED && active && !rearm;
  endsequence
  property p_holdAlign;
    @(posedge clk) disable iff (!rstn)
    s_lockedSteady |=> (state == RBO_LOCKED && $stable(off));
  endproperty
  a_holdAlign: assert property (p_holdAlign) else $error("alignment lost while locked"); // R13

  sequence s_secondBeat;
    take && deserEn && phase;
  endsequence
  property p_singleJoin;
    @(posedge clk) disable iff (!rstn)
    (s_secondBeat ##0 !dbl) |=> (wordValid && wordSlot[1] == BYTE_W'($past(inData))
                                 && wordSlot[0] == BYTE_W'($past(half)));
  endproperty
  a_singleJoin: assert property (p_singleJoin) else $error("single width join wrong"); // R4

  property p_doubleJoin;
    @(posedge clk) disable iff (!rstn)
    (s_secondBeat ##0 dbl) |=> (wordValid && {wordSlot[3], wordSlot[2]} == $past(inData)
                                && {wordSlot[1], wordSlot[0]} == $past(half));
  endproperty
  a_doubleJoin: assert property (p_doubleJoin) else $error("double width join wrong"); // R5

  property p_noOverrun;
    @(posedge clk) disable iff (!rstn)
    wordValid |-> wIf.ready;
  endproperty
  a_noOverrun: assert property (p_noOverrun) else $error("word pushed into full fifo"); // R9
endmodule : rbo_byte_order

// ===== hw/rbo_fifo.sv
// phase compensation fifo with a registered pass-through mode
`timescale 1ns/100ps
module rbo_fifo import rbo_pkg::*; #(
  parameter int W = FIFO_W,
  parameter int DEPTH = PHC_DEPTH
) (
  input wire logic clk, // word clock
  input wire logic rstn, // async reset, active low
  input wire logic bypass, // registered mode select
  rbo_stream_if.snk wr, // write side
  rbo_stream_if.src rd, // read side, registered
  output logic [$clog2(DEPTH):0] level // words held, output stage included
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] cnt;
  logic push;
  logic pop;
  logic load;

  assign load = !rd.valid || rd.ready;
  // registered mode stalls only on the output stage, so latency stays one cycle
  assign wr.ready = bypass ? load : (cnt != FULL); // R9
  assign push = wr.valid && wr.ready && !bypass;
  assign pop = load && (cnt != '0) && !bypass;
  assign level = cnt + {{AW{1'b0}}, rd.valid};

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp] <= wr.data; // R10
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      if (push) begin
        wp <= wp + 1'b1;
      end
      if (pop) begin
        rp <= rp + 1'b1;
      end
      cnt <= cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd.valid <= 1'b0;
      rd.data <= '0;
    end else if (load) begin
      if (bypass) begin
        rd.valid <= wr.valid; // R12
        rd.data <= wr.data;
      end else begin
        rd.valid <= cnt != '0;
        if (cnt != '0) begin
          rd.data <= mem[rp];
        end
      end
    end
  end

  property p_regLatency;
    @(posedge clk) disable iff (!rstn)
    (bypass && wr.valid && wr.ready) |=> (rd.valid && rd.data == $past(wr.data));
  endproperty
  a_regLatency: assert property (p_regLatency) else $error("registered mode latency wrong"); // R12

  property p_fullStall;
    @(posedge clk) disable iff (!rstn)
    (!bypass && cnt == FULL) |-> (!wr.ready && cnt <= FULL);
  endproperty
  a_fullStall: assert property (p_fullStall) else $error("fifo accepted beyond depth"); // R9
endmodule : rbo_fifo

// ===== include/rbo_pkg.sv
// shared constants for the receive byte ordering and phase compensation block
package rbo_pkg;
  localparam int BYTE_W = 10;
  localparam int SLOTS = 4;
  localparam int WORD_W = 40;
  localparam int FIFO_W = 44;
  localparam int IN_W = 20;
  localparam int PHC_DEPTH = 4;
  localparam int LVL_W = 3;
  localparam int ADDR_W = 8;
  localparam int CTRL_W = 6;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_ORDPAT = 8'h04;
  localparam logic [ADDR_W-1:0] REG_PADPAT = 8'h08;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h0c;
  localparam int CTRL_ORD_EN = 0;
  localparam int CTRL_DESER_EN = 1;
  localparam int CTRL_DOUBLE = 2;
  localparam int CTRL_REG_MODE = 3;
  localparam int CTRL_REARM = 4;
  localparam int CTRL_BYTE8 = 5;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h02;
  localparam logic [BYTE_W-1:0] PAT_RESET = 10'h000;
  localparam int ST_LOCKED = 0;
  localparam int ST_PAT_SET = 1;
  localparam int ST_PAD_SET = 2;
  localparam int ST_SEARCH = 3;
  localparam int ST_OFF_LSB = 4;
  localparam int ST_LVL_LSB = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    RBO_IDLE = 3'h1,
    RBO_SEARCH = 3'h2,
    RBO_LOCKED = 3'h4
  } rbo_ord_t;
endpackage : rbo_pkg

// ===== include/rbo_stream_if.sv
// valid/ready word stream between the ordering stage and the phase fifo
`timescale 1ns/100ps
interface rbo_stream_if #(parameter int W = 44);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : rbo_stream_if

// ===== test/rbo_sink_model.sv
// fabric-side sink model: takes output words and can stall on command
`timescale 1ns/100ps
module rbo_sink_model import rbo_pkg::*; (
  input wire logic clk, // word clock, shared with the receive side
  input wire logic rstn, // async reset, active low
  input wire logic stall, // bench command: hold off taking words
  input wire logic [WORD_W-1:0] outData, // word from the block
  input wire logic [SLOTS-1:0] outStat, // pad flags from the block
  input wire logic outValid, // word valid from the block
  output logic outReady // word taken when high with outValid
);
  logic [WORD_W-1:0] qData[$];
  logic [SLOTS-1:0] qStat[$];
  int qCyc[$];
  int cyc;

  // one clock for both sides, so read and write rates never drift apart
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) cyc <= 0;
    else cyc <= cyc + 1;
  end

  // ready is registered: a stall takes effect one edge late, like real fabric logic
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) outReady <= 1'b0;
    else outReady <= !stall;
  end

  always @(posedge clk) begin
    if (rstn && outValid === 1'b1 && outReady) begin
      qData.push_back(outData);
      qStat.push_back(outStat);
      qCyc.push_back(cyc);
    end
  end
endmodule : rbo_sink_model

// ===== test/rx_byte_order_phase_fifo_bench.sv
// self-checking bench for the byte ordering stage and phase fifo
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module rx_byte_order_phase_fifo_bench import rbo_pkg::*;;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [IN_W-1:0] inData = '0;
  logic inValid = 1'b0;
  logic inReady, outValid, outReady;
  logic [WORD_W-1:0] outData;
  logic [SLOTS-1:0] outStat;
  logic stall = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, rd;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp, rsp;
  int n_errors = 0;
  int compares = 0;
  int takeCyc;

  always #25 clk = ~clk;

  rbo_byte_order dut (.clk(clk), .rstn(rstn), .inData(inData), .inValid(inValid),
    .inReady(inReady), .outData(outData), .outStat(outStat), .outValid(outValid),
    .outReady(outReady), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp));

  rbo_sink_model sink (.clk(clk), .rstn(rstn), .stall(stall), .outData(outData),
    .outStat(outStat), .outValid(outValid), .outReady(outReady));

  task automatic wrap_up();
    if (n_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  task automatic hang();
    n_errors++;
    wrap_up();
  endtask : hang

  // write: address and data offered together, each released when taken
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 100);
    if (n >= 100) hang();
    r = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rdr(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 100);
    if (n >= 100) hang();
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask : rdr

  // leaves inValid high so beats can run back to back; idle() drops it
  task automatic send(input logic [IN_W-1:0] d);
    int n;
    n = 0;
    inValid <= 1'b1;
    inData <= d;
    do begin
      @(posedge clk);
      n++;
    end while (inReady !== 1'b1 && n < 100);
    if (n >= 100) hang();
    takeCyc = sink.cyc;
  endtask : send

  task automatic idle();
    inValid <= 1'b0;
    @(posedge clk);
  endtask : idle

  task automatic wait_words(input int k);
    int n;
    for (n = 0; n < 200 && sink.qData.size() < k; n++) @(posedge clk);
    if (sink.qData.size() < k) hang();
  endtask : wait_words

  task automatic t_regs();
    rdr(REG_CTRL, rd, rsp);
    `CHK(rd, {26'h0, CTRL_RESET})
    rdr(8'h10, rd, rsp);
    `CHK({rsp, rd}, {RESP_SLVERR, 32'h0})
    wr(8'h20, 32'h1, 4'hf, rsp);
    `CHK(rsp, RESP_SLVERR)
    wr(REG_STATUS, 32'hffff, 4'hf, rsp);
    rdr(REG_STATUS, rd, rsp);
    `CHK({rsp, rd}, {RESP_OKAY, 32'h0})
  endtask : t_regs

  task automatic t_widths();
    wr(REG_CTRL, 32'h02, 4'hf, rsp);
    send(20'h00155);
    send(20'h002aa);
    idle();
    wait_words(1);
    `CHK(sink.qData.pop_front(), {20'h0, 10'h2aa, 10'h155})
    `CHK(sink.qStat.pop_front(), 4'h0)
    void'(sink.qCyc.pop_front());
    wr(REG_CTRL, 32'h06, 4'hf, rsp);
    send(20'h12345);
    send(20'habcde);
    idle();
    wait_words(1);
    `CHK(sink.qData.pop_front(), 40'habcde12345)
    void'(sink.qStat.pop_front());
    void'(sink.qCyc.pop_front());
  endtask : t_widths

  // deserializer off: each beat is one word; fifo vs registered latency
  task automatic t_latency(input logic [31:0] ctrl, input int lat);
    wr(REG_CTRL, ctrl, 4'hf, rsp);
    send(20'h00077);
    idle();
    wait_words(1);
    `CHK(sink.qCyc.pop_front() - takeCyc, lat + 1)
    void'(sink.qData.pop_front());
    void'(sink.qStat.pop_front());
  endtask : t_latency

  task automatic t_fill();
    int n;
    n = 0;
    wr(REG_CTRL, 32'h00, 4'hf, rsp);
    stall <= 1'b1;
    repeat (2) @(posedge clk);
    inValid <= 1'b1;
    repeat (20) begin
      @(posedge clk);
      if (inReady === 1'b1) n++;
      inData <= IN_W'(n);
    end
    idle();
    `CHK(n, PHC_DEPTH)
    rdr(REG_STATUS, rd, rsp);
    `CHK(rd[10:8], 3'h4)
    stall <= 1'b0;
    wait_words(PHC_DEPTH);
    rdr(REG_STATUS, rd, rsp);
    `CHK(rd[10:8], 3'h0)
    sink.qData.delete();
    sink.qStat.delete();
    sink.qCyc.delete();
  endtask : t_fill

  // pattern 03c sent in the high slot, so a pad shifts it to slot zero
  task automatic t_order();
    wr(REG_CTRL, 32'h03, 4'hf, rsp);
    wr(REG_ORDPAT, 32'h13c, 4'h1, rsp);
    rdr(REG_ORDPAT, rd, rsp);
    `CHK(rd, 32'h03c)
    rdr(REG_STATUS, rd, rsp);
    `CHK(rd[3:0], 4'h2)
    wr(REG_PADPAT, 32'h1f0, 4'hf, rsp);
    repeat (2) @(posedge clk);
    rdr(REG_STATUS, rd, rsp);
    `CHK(rd[3:0], 4'he)
    send(20'h011);
    send(20'h03c);
    send(20'h022);
    send(20'h033);
    send(20'h044);
    send(20'h055);
    send(20'h066);
    send(20'h077);
    idle();
    wait_words(4);
    `CHK(sink.qData[0][9:0], 10'h1f0)
    `CHK(sink.qStat[0][0], 1'b1)
    `CHK(sink.qData[1], {20'h0, 10'h022, 10'h03c})
    `CHK(sink.qStat[1], 4'h0)
    `CHK(sink.qData[2], {20'h0, 10'h044, 10'h033})
    `CHK(sink.qData[3], {20'h0, 10'h066, 10'h055})
    rdr(REG_STATUS, rd, rsp);
    `CHK(rd[6:0], 7'h17)
  endtask : t_order

  // re-arm in double width, then 8-bit compare in single width
  task automatic t_rearm();
    sink.qData.delete();
    sink.qStat.delete();
    sink.qCyc.delete();
    wr(REG_CTRL, 32'h17, 4'hf, rsp);
    send(20'h288a1);
    send(20'h28c3c);
    send(20'h2c8b1);
    send(20'h2d0b3);
    idle();
    wait_words(2);
    `CHK(sink.qData[0], {10'h0a2, 10'h0a1, 10'h1f0, 10'h1f0})
    `CHK(sink.qStat[0], 4'h3)
    `CHK(sink.qData[1], {10'h0b2, 10'h0b1, 10'h0a3, 10'h03c})
    rdr(REG_STATUS, rd, rsp);
    `CHK(rd[6:0], 7'h27)
    wr(REG_CTRL, 32'h33, 4'hf, rsp);
    send(20'h0023c);
    send(20'h00099);
    idle();
    wait_words(3);
    `CHK(sink.qData[2], {20'h0, 10'h099, 10'h23c})
    rdr(REG_STATUS, rd, rsp);
    `CHK(rd[6:0], 7'h07)
  endtask : t_rearm

  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_regs();
    t_widths();
    t_latency(32'h00, 2);
    t_latency(32'h08, 1);
    t_fill();
    t_order();
    t_rearm();
    wrap_up();
  end

  initial begin
    #2ms;
    hang();
  end
endmodule : rx_byte_order_phase_fifo_bench
